// ==== logic/rcpc_consts.svh ====
`ifndef RCPC_CONSTS_SVH
`define RCPC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define RCPC_FLAGS_ADDR       16'hFFAC
`define RCPC_FLAGS_RESET      8'h00

// ----------------------------------------------------------------------------
// Field positions of reset_cause_flags
// ----------------------------------------------------------------------------
`define RCPC_WDOG_BIT         4
`define RCPC_UNDERVOLT_BIT    0

`endif

// ==== logic/rcpc_pkg.sv ====
package rcpc_pkg;

    // ------------------------------------------------------------------------
    // Power-on-clear sequencer states
    // ------------------------------------------------------------------------
    typedef enum logic [0:0] {
        RCPC_POR_HOLD = 1'b0,
        RCPC_POR_RUN  = 1'b1
    } rcpc_por_e;

    // ------------------------------------------------------------------------
    // Internal reset requests, one-cycle pulses on the system clock
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic wdog;
        logic undervolt;
        logic undervolt_default;
    } rcpc_req_s;

    // ------------------------------------------------------------------------
    // CPU bus read request
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] addr;
        logic        rd;
        logic        byte_wide;
    } rcpc_bus_s;

endpackage : rcpc_pkg

// ==== logic/rcpc_por_seq.sv ====
`timescale 1ns/1ps
`default_nettype none

module rcpc_por_seq (
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    input  wire logic low_cmp_ok_i,
    input  wire logic high_cmp_ok_i,
    input  wire logic early_undervolt_start_option_i,
    output logic      por_active_o
);

    // ------------------------------------------------------------------------
    // Comparator and option synchronisers
    // ------------------------------------------------------------------------
    logic [1:0] low_sync_q;
    logic [1:0] high_sync_q;
    logic [1:0] opt_sync_q;
    logic       low_ok;
    logic       high_ok;
    logic       opt_high;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            low_sync_q  <= 2'h0;
            high_sync_q <= 2'h0;
            opt_sync_q  <= 2'h0;
        end else begin
            low_sync_q  <= {low_sync_q[0], low_cmp_ok_i};
            high_sync_q <= {high_sync_q[0], high_cmp_ok_i};
            opt_sync_q  <= {opt_sync_q[0], early_undervolt_start_option_i};
        end
    end

    assign low_ok   = low_sync_q[1];
    assign high_ok  = high_sync_q[1];
    assign opt_high = opt_sync_q[1];

    // ------------------------------------------------------------------------
    // Release and re-assert sequencing
    // ------------------------------------------------------------------------
    rcpc_pkg::rcpc_por_e state_q;
    rcpc_pkg::rcpc_por_e state_d;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            rcpc_pkg::RCPC_POR_HOLD: begin
                // Release threshold follows the option every time, not only at power-up
                if (opt_high ? high_ok : low_ok) begin
                    state_d = rcpc_pkg::RCPC_POR_RUN;
                end
            end
            rcpc_pkg::RCPC_POR_RUN: begin
                if (!low_ok) begin
                    state_d = rcpc_pkg::RCPC_POR_HOLD;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= rcpc_pkg::RCPC_POR_HOLD;
        end else begin
            state_q <= state_d;
        end
    end

    assign por_active_o = (state_q == rcpc_pkg::RCPC_POR_HOLD);

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    a_low_mode_release: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        por_active_o && !opt_high && low_ok |=> !por_active_o)
        else $error("Low threshold mode did not release reset");

    a_high_mode_wait: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        por_active_o && opt_high && !high_ok |=> por_active_o)
        else $error("High threshold mode released without high comparator");

    a_low_reassert: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !por_active_o && !low_ok |=> por_active_o)
        else $error("Reset not re-asserted on low comparator drop");

endmodule : rcpc_por_seq

`default_nettype wire

// ==== logic/rcpc_top.sv ====
// Overview of operation
// - An 8-bit read-only reset cause register; bit and byte-wide reads both return it.
// - Reset pin, power-on-clear and any byte-wide read of the register clear it; a request in the read cycle still sets its flag.
// - Watchdog reset request sets bit 4; zero means none or cleared.
// - Undervoltage reset request sets bit 0; zero means none or cleared.
// - Watchdog or undervoltage reset sets its flag and keeps the other flag.
// - Option 1: release waits for high comparator; low comparator re-asserts reset.
`timescale 1ns/1ps
`default_nettype none
`include "rcpc_consts.svh"

module rcpc_top (
    input  wire logic                clk_sys_i,
    input  wire logic                rst_n_i,
    input  wire logic                ext_reset_n_i,
    input  wire logic                low_cmp_ok_i,
    input  wire logic                high_cmp_ok_i,
    input  wire logic                early_undervolt_start_option_i,
    input  wire rcpc_pkg::rcpc_req_s req_i,
    input  wire rcpc_pkg::rcpc_bus_s bus_i,
    output logic [7:0]               bus_rdata_o,
    output logic                     bus_rvalid_o,
    output logic                     internal_reset_o
);

    // ------------------------------------------------------------------------
    // Reset pin synchroniser
    // ------------------------------------------------------------------------
    logic [1:0] ext_sync_q;
    logic       ext_reset;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ext_sync_q <= 2'h0;
        end else begin
            ext_sync_q <= {ext_sync_q[0], ext_reset_n_i};
        end
    end

    // Held in reset until the pin has been seen high through both stages
    assign ext_reset = !ext_sync_q[1];

    // ------------------------------------------------------------------------
    // Power-on-clear sequencer
    // ------------------------------------------------------------------------
    logic por_active;

    rcpc_por_seq u_por_seq (
        .clk_sys_i                      (clk_sys_i),
        .rst_n_i                        (rst_n_i),
        .low_cmp_ok_i                   (low_cmp_ok_i),
        .high_cmp_ok_i                  (high_cmp_ok_i),
        .early_undervolt_start_option_i (early_undervolt_start_option_i),
        .por_active_o                   (por_active)
    );

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    function automatic logic is_flags_addr(input logic [15:0] addr);
        is_flags_addr = (addr == `RCPC_FLAGS_ADDR);
    endfunction : is_flags_addr

    logic flags_hit;
    logic byte_read;

    assign flags_hit = bus_i.rd && is_flags_addr(bus_i.addr);
    // Bit reads still return data but do not consume the flags
    assign byte_read = flags_hit && bus_i.byte_wide;

    // ------------------------------------------------------------------------
    // Reset cause flags
    // ------------------------------------------------------------------------
    logic       wdog_flag_q;
    logic       wdog_flag_d;
    logic       uv_flag_q;
    logic       uv_flag_d;
    logic       hard_clear;
    logic [7:0] flags_view;

    // Full-chip resets and the default-start reset beat any set in the same cycle
    assign hard_clear = ext_reset || por_active || req_i.undervolt_default;

    always_comb begin
        wdog_flag_d = wdog_flag_q;
        uv_flag_d   = uv_flag_q;
        if (hard_clear) begin
            wdog_flag_d = 1'b0;
            uv_flag_d   = 1'b0;
        end else begin
            // A request landing in the read cycle survives: set wins over clear
            if (byte_read) begin
                wdog_flag_d = 1'b0;
                uv_flag_d   = 1'b0;
            end
            if (req_i.wdog) begin
                wdog_flag_d = 1'b1;
            end
            if (req_i.undervolt) begin
                uv_flag_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wdog_flag_q <= 1'b0;
            uv_flag_q   <= 1'b0;
        end else begin
            wdog_flag_q <= wdog_flag_d;
            uv_flag_q   <= uv_flag_d;
        end
    end

    // Reserved bits read as zero
    always_comb begin
        flags_view                      = `RCPC_FLAGS_RESET;
        flags_view[`RCPC_WDOG_BIT]      = wdog_flag_q;
        flags_view[`RCPC_UNDERVOLT_BIT] = uv_flag_q;
    end

    // ------------------------------------------------------------------------
    // Read data path
    // ------------------------------------------------------------------------
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       rvalid_q;
    logic       rvalid_d;

    always_comb begin
        rdata_d  = rdata_q;
        rvalid_d = flags_hit;
        if (flags_hit) begin
            rdata_d = flags_view;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q  <= `RCPC_FLAGS_RESET;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign bus_rdata_o  = rdata_q;
    assign bus_rvalid_o = rvalid_q;

    // ------------------------------------------------------------------------
    // Combined internal reset
    // ------------------------------------------------------------------------
    logic int_reset_q;
    logic int_reset_d;

    // Registered so that the downstream reset tree sees a glitch-free level
    always_comb begin
        int_reset_d = ext_reset || por_active || req_i.wdog
                      || req_i.undervolt || req_i.undervolt_default;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_reset_q <= 1'b1;
        end else begin
            int_reset_q <= int_reset_d;
        end
    end

    assign internal_reset_o = int_reset_q;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    sequence s_byte_read_quiet;
        byte_read && !hard_clear && !req_i.wdog && !req_i.undervolt;
    endsequence

    sequence s_wdog_only;
        req_i.wdog && !req_i.undervolt && !hard_clear && !byte_read;
    endsequence

    a_read_returns_flags: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        flags_hit |=> bus_rvalid_o && (bus_rdata_o == $past(flags_view)))
        else $error("Read data does not match flags");

    a_reserved_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        bus_rvalid_o |-> (bus_rdata_o & 8'hEE) == 8'h00)
        else $error("Reserved bits read non-zero");

    a_read_clears: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_byte_read_quiet |=> flags_view == 8'h00)
        else $error("Byte read did not clear flags");

    a_pin_clears: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ext_reset || por_active |=> flags_view == 8'h00)
        else $error("Pin or power-on reset did not clear flags");

    a_wdog_sets: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        req_i.wdog && !hard_clear |=> wdog_flag_q
            ##1 (wdog_flag_q || $past(byte_read) || $past(hard_clear)))
        else $error("Watchdog flag not set");

    a_uv_sets: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        req_i.undervolt && !hard_clear |=> uv_flag_q)
        else $error("Undervoltage flag not set");

    a_other_held: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_wdog_only |=> uv_flag_q == $past(uv_flag_q))
        else $error("Watchdog reset disturbed undervoltage flag");

    a_default_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        req_i.undervolt_default |=> !uv_flag_q && !wdog_flag_q)
        else $error("Default-start reset did not clear flags");

endmodule : rcpc_top

`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rcpc_consts.svh"

module testbench;

    // ------------------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------------------
    logic                clk_sys_i;
    logic                rst_n_i;
    logic                ext_reset_n_i;
    logic                low_cmp_ok_i;
    logic                high_cmp_ok_i;
    logic                early_undervolt_start_option_i;
    rcpc_pkg::rcpc_req_s req_i;
    rcpc_pkg::rcpc_bus_s bus_i;
    logic [7:0]          bus_rdata_o;
    logic                bus_rvalid_o;
    logic                internal_reset_o;
    int                  n_errors;
    int                  n_compared;

    localparam logic [7:0] WDOG_V = 8'h01 << `RCPC_WDOG_BIT;
    localparam logic [7:0] UV_V   = 8'h01 << `RCPC_UNDERVOLT_BIT;

    rcpc_top i_dut (
        .clk_sys_i                      (clk_sys_i),
        .rst_n_i                        (rst_n_i),
        .ext_reset_n_i                  (ext_reset_n_i),
        .low_cmp_ok_i                   (low_cmp_ok_i),
        .high_cmp_ok_i                  (high_cmp_ok_i),
        .early_undervolt_start_option_i (early_undervolt_start_option_i),
        .req_i                          (req_i),
        .bus_i                          (bus_i),
        .bus_rdata_o                    (bus_rdata_o),
        .bus_rvalid_o                   (bus_rvalid_o),
        .internal_reset_o               (internal_reset_o)
    );

    // ------------------------------------------------------------------------
    // Compare, access and wait tasks
    // ------------------------------------------------------------------------
    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check_byte

    task automatic check_bit(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    // Answer is registered: sampled just after the edge that takes the strobe
    task automatic read_reg(input logic [15:0] addr, input logic bw, input logic hit,
                            input logic [7:0] exp);
        @(posedge clk_sys_i);
        bus_i <= rcpc_pkg::rcpc_bus_s'{addr: addr, rd: 1'b1, byte_wide: bw};
        @(posedge clk_sys_i);
        bus_i.rd <= 1'b0;
        #1;
        check_bit("bus_rvalid_o", hit, bus_rvalid_o);
        // A missed address leaves the last read data in place
        check_byte("bus_rdata_o", exp, bus_rdata_o);
    endtask : read_reg

    // Optional byte read of the flags in the very cycle of the request
    task automatic pulse(input logic w, input logic u, input logic d, input logic rd);
        @(posedge clk_sys_i);
        req_i <= rcpc_pkg::rcpc_req_s'{wdog: w, undervolt: u, undervolt_default: d};
        if (rd) begin
            bus_i <= rcpc_pkg::rcpc_bus_s'{addr: `RCPC_FLAGS_ADDR, rd: 1'b1, byte_wide: 1'b1};
        end
        @(posedge clk_sys_i);
        req_i <= '0;
        bus_i.rd <= 1'b0;
        #1;
        check_bit("internal_reset_o pulse", 1'b1, internal_reset_o);
        if (rd) begin
            check_bit("bus_rvalid_o with request", 1'b1, bus_rvalid_o);
        end
    endtask : pulse

    // Pins change on a rising edge, like every other bench input
    task automatic set_pins(input logic ext_n, input logic low, input logic high,
                            input logic opt);
        @(posedge clk_sys_i);
        ext_reset_n_i <= ext_n;
        low_cmp_ok_i <= low;
        high_cmp_ok_i <= high;
        early_undervolt_start_option_i <= opt;
    endtask : set_pins

    // Bounded wait covers the input synchronisers
    task automatic wait_level(input logic lvl);
        int i;
        for (i = 0; i < 20 && internal_reset_o !== lvl; i++) begin
            @(posedge clk_sys_i);
            #1;
        end
        check_bit("internal_reset_o", lvl, internal_reset_o);
    endtask : wait_level

    task automatic hold(input int n, input logic lvl);
        repeat (n) @(posedge clk_sys_i);
        #1;
        check_bit("internal_reset_o held", lvl, internal_reset_o);
    endtask : hold

    task automatic print_verdict();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------------------
    // Clock, watchdog
    // ------------------------------------------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    // Whole sequence is a few hundred cycles; this leaves ample margin
    initial begin
        #(25 * 5000);
        n_errors++;
        print_verdict();
    end

    // ------------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------------
    initial begin
        n_errors = 0;
        n_compared = 0;
        rst_n_i = 1'b0;
        ext_reset_n_i = 1'b1;
        low_cmp_ok_i = 1'b0;
        high_cmp_ok_i = 1'b0;
        early_undervolt_start_option_i = 1'b0;
        req_i = '0;
        bus_i = '0;
        repeat (16) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        hold(8, 1'b1);
        set_pins(1'b1, 1'b1, 1'b0, 1'b0);
        wait_level(1'b0);
        read_reg(`RCPC_FLAGS_ADDR, 1'b1, 1'b1, `RCPC_FLAGS_RESET);
        pulse(1'b1, 1'b0, 1'b0, 1'b0);
        read_reg(`RCPC_FLAGS_ADDR, 1'b1, 1'b1, WDOG_V);
        read_reg(`RCPC_FLAGS_ADDR, 1'b1, 1'b1, 8'h00);
        pulse(1'b0, 1'b1, 1'b0, 1'b0);
        read_reg(`RCPC_FLAGS_ADDR, 1'b1, 1'b1, UV_V);
        pulse(1'b1, 1'b0, 1'b0, 1'b0);
        pulse(1'b0, 1'b1, 1'b0, 1'b0);
        read_reg(`RCPC_FLAGS_ADDR, 1'b0, 1'b1, WDOG_V | UV_V);
        read_reg(`RCPC_FLAGS_ADDR, 1'b1, 1'b1, WDOG_V | UV_V);
        read_reg(`RCPC_FLAGS_ADDR, 1'b1, 1'b1, 8'h00);
        read_reg(`RCPC_FLAGS_ADDR + 16'h0001, 1'b1, 1'b0, 8'h00);
        pulse(1'b1, 1'b1, 1'b0, 1'b0);
        pulse(1'b0, 1'b0, 1'b1, 1'b0);
        wait_level(1'b0);
        read_reg(`RCPC_FLAGS_ADDR, 1'b1, 1'b1, 8'h00);
        // Request in the cycle of a clearing read survives it
        pulse(1'b1, 1'b0, 1'b0, 1'b1);
        read_reg(`RCPC_FLAGS_ADDR, 1'b1, 1'b1, WDOG_V);
        read_reg(`RCPC_FLAGS_ADDR, 1'b1, 1'b1, 8'h00);
        // Pin reset after a cause was latched
        pulse(1'b0, 1'b1, 1'b0, 1'b0);
        set_pins(1'b0, 1'b1, 1'b0, 1'b0);
        hold(6, 1'b1);
        set_pins(1'b1, 1'b1, 1'b0, 1'b0);
        wait_level(1'b0);
        read_reg(`RCPC_FLAGS_ADDR, 1'b1, 1'b1, 8'h00);
        // Supply dip below the low comparator clears the flags too
        pulse(1'b1, 1'b0, 1'b0, 1'b0);
        set_pins(1'b1, 1'b0, 1'b0, 1'b0);
        hold(6, 1'b1);
        set_pins(1'b1, 1'b1, 1'b0, 1'b0);
        wait_level(1'b0);
        hold(20, 1'b0);
        read_reg(`RCPC_FLAGS_ADDR, 1'b1, 1'b1, 8'h00);
        // High-threshold release, twice, with low comparator re-asserting
        set_pins(1'b1, 1'b1, 1'b0, 1'b1);
        hold(6, 1'b0);
        set_pins(1'b1, 1'b0, 1'b0, 1'b1);
        hold(6, 1'b1);
        set_pins(1'b1, 1'b1, 1'b0, 1'b1);
        hold(20, 1'b1);
        set_pins(1'b1, 1'b1, 1'b1, 1'b1);
        wait_level(1'b0);
        set_pins(1'b1, 1'b1, 1'b0, 1'b1);
        hold(8, 1'b0);
        set_pins(1'b1, 1'b0, 1'b0, 1'b1);
        hold(6, 1'b1);
        set_pins(1'b1, 1'b1, 1'b0, 1'b1);
        hold(20, 1'b1);
        set_pins(1'b1, 1'b1, 1'b1, 1'b1);
        wait_level(1'b0);
        print_verdict();
    end

endmodule : testbench

`default_nettype wire
